// >>> hdl/meas_io_ctrl.sv
// Processor-side serial control, result counting, trigger and overload logic.
`timescale 1ns/1ps
`include "meas_io_defs.svh"

module meas_io_ctrl
	import meas_io_pkg::*;
#(
	parameter int unsigned          WORD_W     = 12,
	parameter int unsigned          LEN_W      = 4,
	parameter int unsigned          OVF_W      = 16,
	parameter logic [13:0]          LOAD_CYC   = 14'(`LOAD_PULSE_CYC),
	parameter logic [23:0]          FLASH_CYC  = 24'(`FLASH_HALF_CYC)
) (
	input  wire logic               clk,
	input  wire logic               rstn,
	input  wire logic               ce,
	input  wire logic               conv_done_req,
	output logic                    conv_done_out_bit,
	input  wire logic               trig_in_n,
	output logic                    trigger_sense_bit,
	input  wire logic               trig_clear_req,
	input  wire logic               cal_mode,
	input  wire logic               trigger_clear_bit_i,
	output logic                    trigger_clear_bit_o,
	output logic                    trigger_clear_bit_oe,
	output logic                    cal_enable_jumper,
	input  wire logic               word_valid,
	output logic                    word_ready,
	input  wire logic [WORD_W-1:0]  word_data,
	input  wire logic [LEN_W-1:0]   word_len,
	input  wire logic               word_to_source,
	output logic                    serial_ctrl_data_bit,
	output logic                    converter_select_bit,
	output logic                    source_select_bit,
	output logic                    tx_clk_out,
	input  wire logic               result_pulse_in,
	input  wire logic               phase_start,
	input  wire logic               phase_end,
	output logic                    count_irq,
	output logic [7:0]              count_value,
	output logic [OVF_W+7:0]        result_value,
	output logic                    result_valid,
	input  wire logic               source_overload_bit,
	input  wire logic               operate_on,
	output logic                    operate_led
);

	// ----------------------------------------
	// State record
	// ----------------------------------------
	localparam logic [13:0] ZERO_CYC  = 14'(`BIT_ZERO_CYC);
	localparam logic [13:0] ONE_CYC   = 14'(`BIT_ONE_CYC);
	localparam logic [13:0] GAP_CYC   = 14'(`GAP_CYC);
	localparam logic [9:0]  HALF_CYC  = 10'(`TXCLK_HALF_CYC);
	localparam logic [9:0]  DONE_CYC  = 10'(`DONE_PULSE_CYC);

	typedef struct packed {
		logic [3:0]             s1;
		logic [3:0]             s2;
		logic [3:0]             s3;
		logic [3:0]             filt;
		logic [9:0]             done_cnt;
		logic                   done_n;
		logic                   trig_latch;
		logic                   clear_out;
		logic                   jumper;
		tx_state_t              tx;
		logic [13:0]            tx_cnt;
		logic [LEN_W-1:0]       bits_left;
		logic [WORD_W-1:0]      shreg;
		logic                   serial;
		logic                   conv_sel;
		logic                   src_sel;
		logic [9:0]             clk_cnt;
		logic                   txclk;
		logic [7:0]             count;
		logic [OVF_W-1:0]       ovf;
		logic                   irq;
		logic [OVF_W+7:0]       result;
		logic                   res_valid;
		logic [23:0]            flash_cnt;
		logic                   flash;
		logic                   led;
	} state_t;

	state_t r_reg;
	state_t r_next;
	logic   trig_set;
	logic   res_edge;

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		r_next.s1 = {source_overload_bit, result_pulse_in, trigger_clear_bit_i, trig_in_n};
		r_next.s2 = r_reg.s1;
		r_next.s3 = r_reg.s2;
		r_next.filt = (r_reg.filt & (r_reg.s2 ^ r_reg.s3)) | (r_reg.s3 & ~(r_reg.s2 ^ r_reg.s3));
		trig_set = r_reg.filt[`PIN_TRIG_N] & ~r_next.filt[`PIN_TRIG_N];
		res_edge = ~r_reg.filt[`PIN_RESULT] & r_next.filt[`PIN_RESULT];

		// Conversion-complete pulse, active low after the inverting driver.
		r_next.done_n = 1'b1;
		if (r_reg.done_cnt != 10'h000) begin
			r_next.done_cnt = r_reg.done_cnt - 10'h001;
			r_next.done_n = 1'b0;
		end else if (conv_done_req) begin
			r_next.done_cnt = DONE_CYC - 10'h001;
			r_next.done_n = 1'b0;
		end

		// Trigger latch and its shared clear / jumper pin.
		r_next.clear_out = trig_clear_req & ~cal_mode;
		if (trig_set) begin
			r_next.trig_latch = 1'b1;
		end else if (trig_clear_req) begin
			r_next.trig_latch = 1'b0;
		end
		if (cal_mode) begin
			r_next.jumper = r_reg.filt[`PIN_CLEAR_IN];
		end

		// Transmit clock divider.
		if (r_reg.clk_cnt == HALF_CYC - 10'h001) begin
			r_next.clk_cnt = 10'h000;
			r_next.txclk = ~r_reg.txclk;
		end else begin
			r_next.clk_cnt = r_reg.clk_cnt + 10'h001;
		end

		// Pulse-width serial transmitter.
		if (r_reg.tx_cnt != 14'h0000) begin
			r_next.tx_cnt = r_reg.tx_cnt - 14'h0001;
		end
		unique case (r_reg.tx)
			TX_IDLE: begin
				if (word_valid && word_len != '0) begin
					r_next.shreg = word_data << (WORD_W - 32'(word_len));
					r_next.bits_left = word_len;
					r_next.conv_sel = ~word_to_source;
					r_next.src_sel = word_to_source;
					r_next.tx_cnt = GAP_CYC - 14'h0001;
					r_next.tx = TX_GAP;
				end
			end
			TX_GAP: begin
				if (r_reg.tx_cnt == 14'h0000) begin
					r_next.serial = 1'b1;
					if (r_reg.bits_left == '0) begin
						r_next.tx_cnt = LOAD_CYC - 14'h0001;
						r_next.tx = TX_LOAD;
					end else begin
						r_next.tx_cnt = (r_reg.shreg[WORD_W-1] ? ONE_CYC : ZERO_CYC) - 14'h0001;
						r_next.tx = TX_BIT;
					end
				end
			end
			TX_BIT: begin
				if (r_reg.tx_cnt == 14'h0000) begin
					r_next.serial = 1'b0;
					r_next.shreg = r_reg.shreg << 1;
					r_next.bits_left = r_reg.bits_left - LEN_W'(1);
					r_next.tx_cnt = GAP_CYC - 14'h0001;
					r_next.tx = TX_GAP;
				end
			end
			TX_LOAD: begin
				if (r_reg.tx_cnt == 14'h0000) begin
					r_next.serial = 1'b0;
					r_next.tx_cnt = GAP_CYC - 14'h0001;
					r_next.tx = TX_TAIL;
				end
			end
			TX_TAIL: begin
				if (r_reg.tx_cnt == 14'h0000) begin
					r_next.conv_sel = 1'b0;
					r_next.src_sel = 1'b0;
					r_next.tx = TX_IDLE;
				end
			end
		endcase

		// Result pulse counter with overflow count.
		r_next.irq = 1'b0;
		r_next.res_valid = 1'b0;
		if (phase_start) begin
			r_next.count = 8'h00;
			r_next.ovf = `OVF_RESET;
		end else if (res_edge) begin
			r_next.count = r_reg.count + 8'h01;
			if (r_reg.count == 8'hff) begin
				r_next.irq = 1'b1;
				r_next.ovf = r_reg.ovf - OVF_W'(1);
			end
		end
		if (phase_end) begin
			r_next.result = {~r_reg.ovf, r_reg.count};
			r_next.res_valid = 1'b1;
		end

		// Operate indicator flashing under overload.
		if (r_reg.filt[`PIN_OVERLOAD]) begin
			if (r_reg.flash_cnt == 24'h000000) begin
				r_next.flash_cnt = FLASH_CYC - 24'h000001;
				r_next.flash = ~r_reg.flash;
			end else begin
				r_next.flash_cnt = r_reg.flash_cnt - 24'h000001;
			end
			r_next.led = r_reg.flash;
		end else begin
			r_next.flash_cnt = 24'h000000;
			r_next.flash = 1'b1;
			r_next.led = operate_on;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			r_reg <= '0;
			r_reg.s1 <= 4'h1;
			r_reg.s2 <= 4'h1;
			r_reg.s3 <= 4'h1;
			r_reg.filt <= 4'h1;
			r_reg.done_n <= 1'b1;
			r_reg.tx <= TX_IDLE;
			r_reg.ovf <= `OVF_RESET;
			r_reg.flash <= 1'b1;
		end else if (ce) begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign conv_done_out_bit    = r_reg.done_n;
	assign trigger_sense_bit    = r_reg.trig_latch;
	assign trigger_clear_bit_o  = r_reg.clear_out;
	assign trigger_clear_bit_oe = ~cal_mode;
	assign cal_enable_jumper    = r_reg.jumper;
	assign word_ready           = (r_reg.tx == TX_IDLE);
	assign serial_ctrl_data_bit = r_reg.serial;
	assign converter_select_bit = r_reg.conv_sel;
	assign source_select_bit    = r_reg.src_sel;
	assign tx_clk_out           = r_reg.txclk;
	assign count_irq            = r_reg.irq;
	assign count_value          = r_reg.count;
	assign result_value         = r_reg.result;
	assign result_valid         = r_reg.res_valid;
	assign operate_led          = r_reg.led;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	logic [13:0] hi_len;
	logic [13:0] lo_len;
	logic        was_load;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hi_len <= 14'h0000;
			lo_len <= 14'h0000;
			was_load <= 1'b0;
		end else if (ce) begin
			hi_len <= r_next.serial ? hi_len + 14'h0001 : 14'h0000;
			lo_len <= r_next.serial ? 14'h0000 : ((lo_len == 14'h3fff) ? lo_len : lo_len + 14'h0001);
			was_load <= (r_reg.tx == TX_LOAD);
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence done_start_s;
		ce && conv_done_req && r_reg.done_cnt == 10'h000;
	endsequence

	chk_done_pulse: assert property (done_start_s |=> !conv_done_out_bit)
		else $error("Conversion-complete pulse missing.");
	chk_trig_latch: assert property (ce && trig_set |=> trigger_sense_bit)
		else $error("Trigger not latched.");
	chk_trig_clear: assert property (ce && trig_clear_req && !trig_set |=> !trigger_sense_bit)
		else $error("Trigger latch not cleared.");
	chk_jumper_dir: assert property (cal_mode && $past(cal_mode) |-> !trigger_clear_bit_oe && !trigger_clear_bit_o)
		else $error("Clear pin driven during calibration.");
	chk_bit_width: assert property ($fell(serial_ctrl_data_bit) && !was_load |->
		($past(hi_len) == ZERO_CYC || $past(hi_len) == ONE_CYC))
		else $error("Data pulse width wrong.");
	chk_load_width: assert property ($fell(serial_ctrl_data_bit) && was_load |-> $past(hi_len) == LOAD_CYC)
		else $error("Load pulse width wrong.");
	chk_one_select: assert property (serial_ctrl_data_bit |-> converter_select_bit ^ source_select_bit)
		else $error("Select lines wrong during pulse.");
	chk_count_wrap: assert property (ce && res_edge && !phase_start && count_value == 8'hff |=>
		count_irq && count_value == 8'h00)
		else $error("Counter wrap without interrupt.");
	chk_idle_gap: assert property ($rose(serial_ctrl_data_bit) |-> $past(lo_len) >= GAP_CYC)
		else $error("Idle gap too short.");

endmodule : meas_io_ctrl

// >>> hdl/meas_io_defs.svh
// Timing figures and reset values for the measurement input/output control block.
`ifndef MEAS_IO_DEFS_SVH
`define MEAS_IO_DEFS_SVH

// ----------------------------------------
// Clock and serial timing (nanoseconds)
// ----------------------------------------
`define CLK_PERIOD_NS      20
`define TXCLK_PERIOD_NS    12207
`define BIT_ZERO_NS        18000
`define BIT_ONE_NS         50000
`define LOAD_PULSE_NS      200000
`define DONE_PULSE_NS      10000
`define FLASH_HALF_NS      250000000

// ----------------------------------------
// Derived cycle counts
// ----------------------------------------
`define BIT_ZERO_CYC       ((`BIT_ZERO_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define BIT_ONE_CYC        ((`BIT_ONE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOAD_PULSE_CYC     ((`LOAD_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GAP_CYC            ((`TXCLK_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define TXCLK_HALF_CYC     ((`TXCLK_PERIOD_NS / 2) / `CLK_PERIOD_NS)
`define DONE_PULSE_CYC     ((`DONE_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLASH_HALF_CYC     (`FLASH_HALF_NS / `CLK_PERIOD_NS)

// ----------------------------------------
// Reset values and pin positions
// ----------------------------------------
`define OVF_RESET          16'hffff
`define PIN_TRIG_N         0
`define PIN_CLEAR_IN       1
`define PIN_RESULT         2
`define PIN_OVERLOAD       3

`endif

// >>> hdl/meas_io_pkg.sv
// Types shared by the measurement input/output control block.
package meas_io_pkg;

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_GAP,
		TX_BIT,
		TX_LOAD,
		TX_TAIL
	} tx_state_t;

endpackage : meas_io_pkg

// >>> tb/far_side_model.sv
// Behavioural model of the isolated receivers, converter pulse source and source overload sense.
`timescale 1ns/1ps

module far_side_model #(
	parameter int LOAD = 40
) (
	input  wire logic        clk,
	input  wire logic        serial,
	input  wire logic        conv_sel,
	input  wire logic        src_sel,
	input  wire logic        over_limit,
	input  wire logic        phase_run,
	output logic             overload,
	output logic             result_pulse = 1'b0,
	output logic             load_stb = 1'b0,
	output logic [17:0]      word = '0,
	output int               bad = 0
);
	int         hi = 0;
	int         lo = 1000;
	int         n = 0;
	logic [11:0] sh = '0;
	logic [2:0]  div = '0;
	logic        run_q = 1'b0;

	assign overload = over_limit;

	// Pulse widths are measured while the line is high and decoded when it falls.
	always @(posedge clk) begin
		load_stb <= 1'b0;
		div <= div + 3'd1;
		if (div == 3'd7) run_q <= phase_run;
		result_pulse <= run_q & div[2];
		if (serial) begin
			hi <= hi + 1;
		end else begin
			if (hi != 0 && lo < 611) bad <= bad + 1;
			if (hi == 900 || hi == 2500) begin
				sh <= {sh[10:0], hi == 2500};
				n <= n + 1;
			end else if (hi == LOAD) begin
				word <= {src_sel, conv_sel, 4'(n), sh};
				load_stb <= 1'b1;
				sh <= '0;
				n <= 0;
			end else if (hi != 0) begin
				bad <= bad + 1;
			end
			lo <= (hi != 0) ? 1 : lo + 1;
			hi <= 0;
		end
	end
endmodule : far_side_model

// >>> tb/tb.sv
// Self-checking testbench for the measurement input/output control block.
`timescale 1ns/1ps

module tb;
	import meas_io_pkg::*;
	logic        clk = 0, rstn = 0, ce = 1, conv_done_req = 0, trig_in_n = 1, trig_clear_req = 0;
	logic        cal_mode = 0, jumper = 0, clr_pin, word_valid = 0, word_to_source = 0;
	logic [11:0] word_data = '0;
	logic [3:0]  word_len = '0;
	logic        over_limit = 0, phase_run = 0, phase_start = 0, phase_end = 0, operate_on = 0;
	logic        conv_done_out_bit, trigger_sense_bit, trigger_clear_bit_o, trigger_clear_bit_oe;
	logic        cal_enable_jumper, word_ready, serial_ctrl_data_bit, converter_select_bit;
	logic        source_select_bit, tx_clk_out, result_pulse, count_irq, result_valid;
	logic        source_overload_bit, operate_led, load_stb;
	logic [7:0]  count_value;
	logic [23:0] result_value;
	logic [17:0] rx_word;
	int          bad, error_cnt = 0, n_checks = 0, npulse = 0, nirq = 0, k, tog;
	logic        prev_lvl;
	integer      seed = 32'he3be;
	logic [17:0] q[$];
	time         t0;

	assign clr_pin = trigger_clear_bit_oe ? trigger_clear_bit_o : jumper;

	meas_io_ctrl #(.LOAD_CYC(14'd40), .FLASH_CYC(24'd20)) u_dut (.clk(clk), .rstn(rstn), .ce(ce),
		.conv_done_req(conv_done_req), .conv_done_out_bit(conv_done_out_bit), .trig_in_n(trig_in_n),
		.trigger_sense_bit(trigger_sense_bit), .trig_clear_req(trig_clear_req), .cal_mode(cal_mode),
		.trigger_clear_bit_i(clr_pin), .trigger_clear_bit_o(trigger_clear_bit_o),
		.trigger_clear_bit_oe(trigger_clear_bit_oe), .cal_enable_jumper(cal_enable_jumper),
		.word_valid(word_valid), .word_ready(word_ready), .word_data(word_data), .word_len(word_len),
		.word_to_source(word_to_source), .serial_ctrl_data_bit(serial_ctrl_data_bit),
		.converter_select_bit(converter_select_bit), .source_select_bit(source_select_bit),
		.tx_clk_out(tx_clk_out), .result_pulse_in(result_pulse), .phase_start(phase_start),
		.phase_end(phase_end), .count_irq(count_irq), .count_value(count_value),
		.result_value(result_value), .result_valid(result_valid),
		.source_overload_bit(source_overload_bit), .operate_on(operate_on), .operate_led(operate_led));

	far_side_model #(.LOAD(40)) u_far (.clk(clk), .serial(serial_ctrl_data_bit),
		.conv_sel(converter_select_bit), .src_sel(source_select_bit), .over_limit(over_limit),
		.phase_run(phase_run), .overload(source_overload_bit), .result_pulse(result_pulse),
		.load_stb(load_stb), .word(rx_word), .bad(bad));

	// ----------------------------------------
	// Checking and reporting
	// ----------------------------------------
	task chk_val(input logic [23:0] got, input logic [23:0] exp);
		n_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk_val

	task chk_bit(input logic got, input logic exp);
		chk_val({23'h0, got}, {23'h0, exp});
	endtask : chk_bit

	task summarize;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : summarize

	task send(input logic src, input logic [3:0] len, input logic [11:0] d);
		q.push_back({src, ~src, len, d});
		@(posedge clk);
		word_valid <= 1;
		word_to_source <= src;
		word_len <= len;
		word_data <= d;
		@(posedge clk);
		word_valid <= 0;
		repeat (3) @(posedge clk);
		k = 0;
		while (word_ready !== 1'b1 && k < 60000) begin
			@(posedge clk);
			k++;
		end
		chk_bit(k < 60000, 1'b1);
	endtask : send

	always @(posedge clk) if (load_stb) chk_val(rx_word, q.pop_front());
	always @(posedge clk) if (count_irq === 1'b1) nirq++;
	always @(posedge result_pulse) npulse++;

	initial begin
		forever #10 clk = ~clk;
	end

	initial begin
		#1800000;
		error_cnt++;
		summarize();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1;
		repeat (5) @(posedge clk);
		conv_done_req <= 1;
		@(posedge clk);
		conv_done_req <= 0;
		k = 0;
		@(negedge clk);
		while (conv_done_out_bit === 1'b0 && k < 600) begin
			k++;
			@(negedge clk);
		end
		chk_val(24'(k), 24'd500);
		$display("test done pulse finished");
		@(posedge clk);
		trig_in_n <= 0;
		repeat (3) @(posedge clk);
		trig_in_n <= 1;
		repeat (8) @(negedge clk);
		chk_bit(trigger_sense_bit, 1'b1);
		@(posedge clk);
		trig_clear_req <= 1;
		@(posedge clk);
		trig_clear_req <= 0;
		@(negedge clk);
		chk_bit(trigger_clear_bit_o, 1'b1);
		chk_bit(trigger_sense_bit, 1'b0);
		@(posedge clk);
		cal_mode <= 1;
		jumper <= 1;
		repeat (8) @(negedge clk);
		chk_bit(trigger_clear_bit_oe, 1'b0);
		chk_bit(cal_enable_jumper, 1'b1);
		@(posedge clk);
		jumper <= 0;
		repeat (8) @(negedge clk);
		chk_bit(cal_enable_jumper, 1'b0);
		@(posedge clk);
		cal_mode <= 0;
		$display("test trigger finished");
		@(posedge tx_clk_out);
		t0 = $time;
		@(posedge tx_clk_out);
		chk_val(24'(($time - t0) / 20), 24'd610);
		@(posedge clk);
		ce <= 1'b0;
		@(negedge clk);
		prev_lvl = tx_clk_out;
		repeat (400) @(negedge clk);
		chk_bit(tx_clk_out, prev_lvl);
		@(posedge clk);
		ce <= 1'b1;
		word_valid <= 1'b1;
		word_len <= 4'h0;
		repeat (20) @(posedge clk);
		word_valid <= 1'b0;
		@(negedge clk);
		chk_bit(word_ready, 1'b1);
		send(1'b0, 4'd1, 12'($random(seed)) & 12'h001);
		send(1'b0, 4'd4, 12'($random(seed)) & 12'h00f);
		send(1'b1, 4'd12, 12'($random(seed)));
		chk_val(24'(q.size()), 24'd0);
		chk_val(24'(bad), 24'd0);
		$display("test serial words finished");
		@(posedge clk);
		phase_start <= 1;
		@(posedge clk);
		phase_start <= 0;
		npulse = 0;
		phase_run <= 1;
		repeat (2400) @(posedge clk);
		phase_run <= 0;
		repeat (40) @(posedge clk);
		chk_val(24'(nirq), 24'(npulse / 256));
		chk_val({16'h0000, count_value}, 24'(npulse % 256));
		phase_end <= 1;
		@(posedge clk);
		phase_end <= 0;
		@(negedge clk);
		chk_bit(result_valid, 1'b1);
		chk_val(result_value, 24'(npulse));
		$display("test counter finished");
		@(posedge clk);
		operate_on <= 1'b1;
		repeat (8) @(negedge clk);
		chk_bit(operate_led, 1'b1);
		@(posedge clk);
		over_limit <= 1'b1;
		tog = 0;
		prev_lvl = operate_led;
		repeat (200) begin
			@(negedge clk);
			if (operate_led !== prev_lvl) tog++;
			prev_lvl = operate_led;
		end
		chk_bit(tog >= 8 && tog <= 11, 1'b1);
		@(posedge clk);
		over_limit <= 1'b0;
		repeat (30) @(negedge clk);
		chk_bit(operate_led, 1'b1);
		$display("test overload finished");
		summarize();
	end
endmodule : tb
